// ---- rtl/sram_ctrl_params.svh ----
// Purpose: Offsets, field positions, reset values and cycle counts for the SRAM control slice
// Assumes: Included by bare name; definitions only
// Notes: Cycle figures are in clock cycles of aclk
`ifndef SRAM_CTRL_PARAMS_SVH
`define SRAM_CTRL_PARAMS_SVH

// Register byte offsets
`define REG_CFG_OFFSET 12'h000
`define REG_STATUS_OFFSET 12'h004
`define REG_BURST_ADDR_OFFSET 12'h008
`define REG_UNSELECT_COUNT_OFFSET 12'h00C

// Configuration fields
`define CFG_FORCE_LINEAR_BIT 0
`define CFG_SW_SLEEP_BIT 1
`define CFG_RESET_VALUE 32'h0000_0000

// Status fields
`define STATUS_SNOOZE_BIT 0
`define STATUS_IGNORED_BIT 1
`define STATUS_SELECTED_BIT 2
`define STATUS_OUT_ENABLED_BIT 3
`define STATUS_COUNT_LSB 4

// Sleep timing, in cycles
`define SLEEP_ENTRY_IGNORE_DELAY 2
`define SLEEP_EXIT_SAMPLE_DELAY 2
`define SLEEP_ENTRY_CURRENT_DELAY 2
`define SLEEP_EXIT_CURRENT_DELAY 0
`define SLEEP_PIPE_CYCLES (`SLEEP_EXIT_SAMPLE_DELAY)

// Output disable delay after unselect, in cycles
`define UNSELECT_DISABLE_CYCLES 2

`endif

// ---- rtl/sram_ctrl_pkg.sv ----
// Purpose: Shared types for the SRAM control slice
// Assumes: Used only through scoped names
// Notes: AXI response codes follow the published encoding
package sram_ctrl_pkg;
  typedef logic [1:0] axi_resp_t;
  typedef enum logic [1:0] {RESP_OKAY = 2'b00, RESP_SLVERR = 2'b10} resp_code_e;
  typedef enum {ORDER_INTERLEAVED, ORDER_LINEAR} burst_order_e;
endpackage

// ---- rtl/burst_link_if.sv ----
// Purpose: Carries burst sequencing signals between control and generator
// Assumes: Single clock domain
// Notes: Generator output is combinational from its count
`timescale 1ns/1ps
`default_nettype none
interface burst_link_if #(parameter int BURST_BITS = 2);
  logic load;
  logic advance;
  logic [BURST_BITS-1:0] base;
  sram_ctrl_pkg::burst_order_e order;
  logic [BURST_BITS-1:0] count;
  logic [BURST_BITS-1:0] next_low;
  modport ctl (output load, output advance, output base, output order,
               input count, input next_low);
  modport gen (input load, input advance, input base, input order,
               output count, output next_low);
endinterface
`default_nettype wire

// ---- rtl/burst_addr_gen.sv ----
// Purpose: Burst counter and low address combine for interleaved or linear order
// Assumes: load and advance never high together
// Notes: Count wraps at the burst length
`timescale 1ns/1ps
`default_nettype none
module burst_addr_gen #(
  parameter int BURST_BITS = 2
) (
  input wire logic aclk,
  input wire logic aresetn,
  burst_link_if.gen link
);
  logic [BURST_BITS-1:0] count_reg;
  logic [BURST_BITS-1:0] count_next;

  always_comb
  begin
    count_next = count_reg + {{(BURST_BITS-1){1'b0}}, 1'b1};
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      count_reg <= '0;
    else if (link.load)
      count_reg <= '0;
    else if (link.advance)
      count_reg <= count_next;
  end

  assign link.count = count_reg;
  assign link.next_low = (link.order == sram_ctrl_pkg::ORDER_LINEAR) ?
                         link.base + count_next : link.base ^ count_next;
endmodule
`default_nettype wire

// ---- rtl/sync_sram_snooze_burst_ctrl.sv ----
// Purpose: Sleep timing, burst sequencing, deselect output disable and chip select
// Assumes: Pins synchronous to aclk; AXI4-Lite register access
// Notes: Array data path and byte-write logic live elsewhere
//
// Chosen here: the placing of the registers and the AXI4-Lite register port.
`timescale 1ns/1ps
`default_nettype none
`include "sram_ctrl_params.svh"
module sync_sram_snooze_burst_ctrl #(
  parameter int ADDR_W = 20,
  parameter int BURST_BITS = 2
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic sleep_request,
  input wire logic linear_burst_order_n,
  input wire logic chip_select_first_n,
  input wire logic chip_select_second,
  input wire logic chip_select_third_n,
  input wire logic addr_strobe_n,
  input wire logic burst_advance_n,
  input wire logic global_write_n,
  input wire logic byte_write_gate_n,
  input wire logic [ADDR_W-1:0] addr,
  output logic [ADDR_W-1:0] burst_addr,
  output logic data_out_en_n,
  output logic snooze,
  output logic inputs_ignored,
  input wire logic [11:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [11:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready
);
  localparam int PIPE = `SLEEP_PIPE_CYCLES;

  burst_link_if #(.BURST_BITS(BURST_BITS)) link ();
  logic [31:0] cfg_reg, unselect_count_reg;
  logic [PIPE-1:0] sleep_pipe_reg;
  logic snooze_reg, ignored_reg, selected_reg;
  logic [ADDR_W-1:0] addr_cap_reg, burst_addr_reg;
  logic [BURST_BITS-1:0] start_low_reg;
  logic read_q1_reg, unsel_q1_reg, oe_n_reg;
  logic sleep_eff, accept, sel_now, start_sel, unselect_command, adv_sel, read_start;
  logic awready_reg, wready_reg, aw_held_reg, w_held_reg;
  logic bvalid_reg, arready_reg, rvalid_reg, read_hit;
  logic [11:0] awaddr_reg;
  logic [31:0] wdata_reg, rdata_reg, read_mux, cfg_next;
  logic [3:0] wstrb_reg;
  sram_ctrl_pkg::axi_resp_t bresp_reg, rresp_reg;

  // Pin request or software request both put the slice to sleep
  assign sleep_eff = sleep_request | cfg_reg[`CFG_SW_SLEEP_BIT];
  // Inputs honoured only once the sleep pipe has drained
  assign accept = ~|sleep_pipe_reg;
  assign sel_now = !chip_select_first_n && chip_select_second && !chip_select_third_n;
  assign start_sel = accept && !addr_strobe_n && sel_now;
  assign unselect_command = accept && !addr_strobe_n && !sel_now;
  assign adv_sel = accept && addr_strobe_n && !burst_advance_n && sel_now;
  assign read_start = start_sel && global_write_n && byte_write_gate_n;

  assign link.load = start_sel;
  assign link.advance = adv_sel;
  assign link.base = start_low_reg;
  // Floating order pin is pulled high, giving interleaved order
  assign link.order = (!linear_burst_order_n || cfg_reg[`CFG_FORCE_LINEAR_BIT]) ?
                      sram_ctrl_pkg::ORDER_LINEAR : sram_ctrl_pkg::ORDER_INTERLEAVED;

  burst_addr_gen #(.BURST_BITS(BURST_BITS)) u_gen (
    .aclk(aclk),
    .aresetn(aresetn),
    .link(link)
  );

  // Sleep request pipeline; its length sets the resume delay, while ignoring starts one edge after the request
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      sleep_pipe_reg <= '0;
    else
      sleep_pipe_reg <= {sleep_pipe_reg[PIPE-2:0], sleep_eff};
  end

  // Snooze follows the request one cycle later, both on entry and on exit
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      snooze_reg <= 1'b0;
      ignored_reg <= 1'b0;
    end
    else
    begin
      snooze_reg <= sleep_eff;
      ignored_reg <= ~(~|{sleep_pipe_reg[PIPE-2:0], sleep_eff});
    end
  end

  // Address and selection capture; held while asleep
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      addr_cap_reg <= '0;
      selected_reg <= 1'b0;
    end
    else if (accept)
    begin
      addr_cap_reg <= addr;
      selected_reg <= sel_now;
    end
  end

  // Start bits kept apart: interleave needs them, not the running address; sleep clears nothing
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      burst_addr_reg <= '0;
      start_low_reg <= '0;
    end
    else if (start_sel)
    begin
      burst_addr_reg <= addr;
      start_low_reg <= addr[BURST_BITS-1:0];
    end
    else if (adv_sel)
      burst_addr_reg[BURST_BITS-1:0] <= link.next_low;
  end

  // Double-cycle deselect: disable lands on the second edge after unselect
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      read_q1_reg <= 1'b0;
      unsel_q1_reg <= 1'b0;
      oe_n_reg <= 1'b1;
    end
    else
    begin
      read_q1_reg <= read_start;
      unsel_q1_reg <= unselect_command;
      if (unsel_q1_reg)
        oe_n_reg <= 1'b1;
      else if (read_q1_reg)
        oe_n_reg <= 1'b0;
    end
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      unselect_count_reg <= 32'h0000_0000;
    else if (unselect_command)
      unselect_count_reg <= unselect_count_reg + 32'h0000_0001;
  end

  // AXI write address and data are taken independently
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      awready_reg <= 1'b0;
      aw_held_reg <= 1'b0;
      awaddr_reg <= 12'h000;
    end
    else if (s_axi_awvalid && awready_reg)
    begin
      aw_held_reg <= 1'b1;
      awaddr_reg <= s_axi_awaddr;
      awready_reg <= 1'b0;
    end
    else if (aw_held_reg && w_held_reg && !bvalid_reg)
      aw_held_reg <= 1'b0;
    else if (!aw_held_reg && !bvalid_reg)
      awready_reg <= 1'b1;
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      wready_reg <= 1'b0;
      w_held_reg <= 1'b0;
      wdata_reg <= 32'h0000_0000;
      wstrb_reg <= 4'h0;
    end
    else if (s_axi_wvalid && wready_reg)
    begin
      w_held_reg <= 1'b1;
      wdata_reg <= s_axi_wdata;
      wstrb_reg <= s_axi_wstrb;
      wready_reg <= 1'b0;
    end
    else if (aw_held_reg && w_held_reg && !bvalid_reg)
      w_held_reg <= 1'b0;
    else if (!w_held_reg && !bvalid_reg)
      wready_reg <= 1'b1;
  end

  always_comb
  begin
    cfg_next = cfg_reg;
    // Only the low two bits hold live bits
    if (wstrb_reg[0])
      cfg_next[7:0] = wdata_reg[7:0];
    cfg_next[31:2] = 30'h0;
  end

  // Only the configuration word is writable; others answer SLVERR
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      cfg_reg <= `CFG_RESET_VALUE;
      bvalid_reg <= 1'b0;
      bresp_reg <= sram_ctrl_pkg::RESP_OKAY;
    end
    else if (aw_held_reg && w_held_reg && !bvalid_reg)
    begin
      bvalid_reg <= 1'b1;
      if (awaddr_reg[11:2] == 10'(`REG_CFG_OFFSET >> 2))
      begin
        cfg_reg <= cfg_next;
        bresp_reg <= sram_ctrl_pkg::RESP_OKAY;
      end
      else
        bresp_reg <= sram_ctrl_pkg::RESP_SLVERR;
    end
    else if (bvalid_reg && s_axi_bready)
      bvalid_reg <= 1'b0;
  end

  always_comb
  begin
    read_mux = 32'h0000_0000;
    read_hit = 1'b1;
    case (s_axi_araddr[11:2])
      10'(`REG_CFG_OFFSET >> 2):
        read_mux = cfg_reg;
      10'(`REG_STATUS_OFFSET >> 2):
      begin
        read_mux[`STATUS_SNOOZE_BIT] = snooze_reg;
        read_mux[`STATUS_IGNORED_BIT] = ignored_reg;
        read_mux[`STATUS_SELECTED_BIT] = selected_reg;
        read_mux[`STATUS_OUT_ENABLED_BIT] = !oe_n_reg;
        read_mux[`STATUS_COUNT_LSB +: BURST_BITS] = link.count;
      end
      10'(`REG_BURST_ADDR_OFFSET >> 2):
        read_mux[ADDR_W-1:0] = burst_addr_reg;
      10'(`REG_UNSELECT_COUNT_OFFSET >> 2):
        read_mux = unselect_count_reg;
      default:
        read_hit = 1'b0;
    endcase
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      arready_reg <= 1'b0;
      rvalid_reg <= 1'b0;
      rdata_reg <= 32'h0000_0000;
      rresp_reg <= sram_ctrl_pkg::RESP_OKAY;
    end
    else if (s_axi_arvalid && arready_reg)
    begin
      arready_reg <= 1'b0;
      rvalid_reg <= 1'b1;
      rdata_reg <= read_mux;
      rresp_reg <= read_hit ? sram_ctrl_pkg::RESP_OKAY : sram_ctrl_pkg::RESP_SLVERR;
    end
    else if (rvalid_reg && s_axi_rready)
      rvalid_reg <= 1'b0;
    else if (!rvalid_reg)
      arready_reg <= 1'b1;
  end

  assign burst_addr = burst_addr_reg;
  assign data_out_en_n = oe_n_reg;
  assign snooze = snooze_reg;
  assign inputs_ignored = ignored_reg;
  assign s_axi_awready = awready_reg;
  assign s_axi_wready = wready_reg;
  assign s_axi_bvalid = bvalid_reg;
  assign s_axi_bresp = bresp_reg;
  assign s_axi_arready = arready_reg;
  assign s_axi_rvalid = rvalid_reg;
  assign s_axi_rdata = rdata_reg;
  assign s_axi_rresp = rresp_reg;

  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);

  sequence s_release;
    !sleep_eff ##1 !sleep_eff;
  endsequence

  a_sleep_ignore_entry: assert property (sleep_eff |=> !accept)
    else $error("inputs still accepted after sleep request");
  a_sleep_resume_hold: assert property ($fell(sleep_eff) |-> !accept ##1 !accept)
    else $error("inputs sampled too early after sleep release");
  a_sleep_resume_go: assert property (s_release ##1 !sleep_eff |-> accept)
    else $error("inputs not sampled two cycles after release");
  a_snooze_entry: assert property (sleep_eff |-> ##[1:2] snooze_reg)
    else $error("snooze not reached within two cycles");
  a_snooze_exit: assert property ($fell(sleep_eff) |=> !snooze_reg)
    else $error("snooze not left after release");
  a_burst_xor: assert property (adv_sel && link.order == sram_ctrl_pkg::ORDER_INTERLEAVED
    |=> burst_addr_reg[BURST_BITS-1:0] == ($past(link.base)
    ^ BURST_BITS'($past(link.count) + 1)))
    else $error("interleaved burst address wrong");
  a_burst_add: assert property (adv_sel && link.order == sram_ctrl_pkg::ORDER_LINEAR
    |=> burst_addr_reg[BURST_BITS-1:0] == BURST_BITS'($past(link.base)
    + $past(link.count) + 1))
    else $error("linear burst address wrong");
  a_unselect_disable: assert property (unselect_command |-> ##[1:2] oe_n_reg)
    else $error("outputs not disabled after unselect");
  a_addr_capture: assert property (accept |=> addr_cap_reg == $past(addr))
    else $error("address not captured on accepted edge");
  a_select_decode: assert property (accept |=> selected_reg == $past(!chip_select_first_n
    && chip_select_second && !chip_select_third_n))
    else $error("chip select decode wrong");
  a_sleep_retain: assert property (!accept |=> $stable(burst_addr_reg))
    else $error("burst state changed while asleep");
endmodule
`default_nettype wire

// ---- tb/sram_bus_master_model.sv ----
// Purpose: Memory controller model driving the SRAM control pins
// Assumes: Pins change by non-blocking assignment right after aclk rises
// Notes: Both write pins share one level, so a start is a read or a full write
`timescale 1ns/1ps
`default_nettype none
module sram_bus_master_model (
  input wire logic aclk,
  output logic sleep_request,
  output logic linear_burst_order_n,
  output logic [2:0] cs,
  output logic addr_strobe_n,
  output logic burst_advance_n,
  output logic write_n,
  output logic [19:0] addr
);
  initial
  begin
    sleep_request = 1'b0;
    linear_burst_order_n = 1'b1;
    cs = 3'b101;
    addr_strobe_n = 1'b1;
    burst_advance_n = 1'b1;
    write_n = 1'b1;
    addr = 20'h0_0000;
  end
  // Controls set up only for one selected edge, then back to idle
  task automatic cmd(input logic [2:0] c, input logic st_n, input logic adv_n,
                     input logic [19:0] a);
    @(posedge aclk);
    cs <= c;
    addr_strobe_n <= st_n;
    burst_advance_n <= adv_n;
    addr <= a;
    @(posedge aclk);
    cs <= 3'b101;
    addr_strobe_n <= 1'b1;
    burst_advance_n <= 1'b1;
  endtask
  // No command until the wake interval has passed
  task automatic set_sleep(input logic s);
    @(posedge aclk);
    sleep_request <= s;
    if (!s)
      repeat (2) @(posedge aclk);
  endtask
  task automatic set_write(input logic w);
    @(posedge aclk);
    write_n <= w;
  endtask
  task automatic set_order(input logic o);
    @(posedge aclk);
    linear_burst_order_n <= o;
  endtask
endmodule
`default_nettype wire

// ---- tb/sync_sram_snooze_burst_ctrl_tb.sv ----
// Purpose: Self-checking bench for the SRAM control slice
// Assumes: Pins from the controller model, registers over AXI4-Lite
// Notes: Burst order checked with base low bits 01, where xor and add differ
`timescale 1ns/1ps
`default_nettype none
`include "sram_ctrl_params.svh"
module sync_sram_snooze_burst_ctrl_tb;
  logic aclk = 1'b0;
  logic aresetn = 1'b0;
  logic sleep_request, linear_burst_order_n, addr_strobe_n, burst_advance_n, write_n;
  logic [2:0] cs;
  logic [19:0] addr, burst_addr;
  logic data_out_en_n, snooze, inputs_ignored;
  logic [11:0] awaddr = 12'h000;
  logic [11:0] araddr = 12'h000;
  logic [31:0] wdata = 32'h0000_0000;
  logic awvalid = 1'b0;
  logic wvalid = 1'b0;
  logic bready = 1'b0;
  logic arvalid = 1'b0;
  logic rready = 1'b0;
  logic awready, wready, bvalid, arready, rvalid;
  logic [1:0] bresp, rresp, r;
  logic [31:0] rdata, d;
  int error_cnt = 0;
  int samples_checked = 0;
  initial
  begin
    forever #10 aclk = ~aclk;
  end
  sram_bus_master_model u_host (.aclk(aclk), .sleep_request(sleep_request),
    .linear_burst_order_n(linear_burst_order_n), .cs(cs), .addr_strobe_n(addr_strobe_n),
    .burst_advance_n(burst_advance_n), .write_n(write_n), .addr(addr));
  sync_sram_snooze_burst_ctrl u_dut (.aclk(aclk), .aresetn(aresetn),
    .sleep_request(sleep_request), .linear_burst_order_n(linear_burst_order_n),
    .chip_select_first_n(cs[2]), .chip_select_second(cs[1]), .chip_select_third_n(cs[0]),
    .addr_strobe_n(addr_strobe_n), .burst_advance_n(burst_advance_n),
    .global_write_n(write_n), .byte_write_gate_n(write_n), .addr(addr),
    .burst_addr(burst_addr), .data_out_en_n(data_out_en_n), .snooze(snooze),
    .inputs_ignored(inputs_ignored), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
    .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hf),
    .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
    .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
    .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
    .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready));
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp)
    begin
      error_cnt++;
      $display("Error at %0t: saw %h, expected %h", $time, seen, exp);
    end
  endtask
  task automatic report_and_stop();
    if (error_cnt == 0 && samples_checked > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  task automatic axi_wr(input logic [11:0] a, input logic [31:0] v);
    bit aw_ok;
    bit w_ok;
    aw_ok = 0;
    w_ok = 0;
    @(posedge aclk);
    awaddr <= a;
    wdata <= v;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    while (!(aw_ok && w_ok))
    begin
      @(posedge aclk);
      if (!aw_ok && awready === 1'b1)
      begin
        aw_ok = 1;
        awvalid <= 1'b0;
      end
      if (!w_ok && wready === 1'b1)
      begin
        w_ok = 1;
        wvalid <= 1'b0;
      end
    end
    do @(posedge aclk); while (bvalid !== 1'b1);
    r = bresp;
    bready <= 1'b0;
  endtask
  task automatic axi_rd(input logic [11:0] a);
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do @(posedge aclk); while (arready !== 1'b1);
    arvalid <= 1'b0;
    do @(posedge aclk); while (rvalid !== 1'b1);
    d = rdata;
    r = rresp;
    rready <= 1'b0;
  endtask
  task automatic settle(input int n);
    repeat (n) @(posedge aclk);
    #1;
  endtask
  initial
  begin
    repeat (20000) @(posedge aclk);
    error_cnt++;
    report_and_stop();
  end
  initial
  begin
    logic [19:0] base;
    logic [1:0] lo;
    base = 20'h0_0A51;
    repeat (16) @(posedge aclk);
    aresetn <= 1'b1;
    repeat (2) @(posedge aclk);
    axi_rd(`REG_CFG_OFFSET);
    check(d, `CFG_RESET_VALUE);
    axi_rd(`REG_STATUS_OFFSET);
    check(d, 32'h0000_0000);
    axi_rd(12'h010);
    check(d, 32'h0000_0000);
    check(r, sram_ctrl_pkg::RESP_SLVERR);
    axi_wr(`REG_STATUS_OFFSET, 32'h0000_0001);
    check(r, sram_ctrl_pkg::RESP_SLVERR);
    // Every select combination, each followed by a plain unselect
    for (int i = 0; i < 8; i++)
    begin
      u_host.cmd(i[2:0], 1'b0, 1'b1, 20'h0_0100 + i);
      settle(2);
      check(data_out_en_n, i[2:0] != 3'b010);
      if (i[2:0] == 3'b010)
        check(burst_addr, 20'h0_0102);
      u_host.cmd(3'b111, 1'b0, 1'b1, 20'h0_0000);
      settle(2);
      check(data_out_en_n, 1'b1);
    end
    // A write start must leave the data outputs off
    u_host.set_write(1'b0);
    u_host.cmd(3'b010, 1'b0, 1'b1, 20'h0_0200);
    settle(2);
    check(data_out_en_n, 1'b1);
    u_host.set_write(1'b1);
    axi_rd(`REG_UNSELECT_COUNT_OFFSET);
    check(d, 32'h0000_000F);
    // Pin low, pin high, pin high with software forcing linear
    for (int o = 0; o < 3; o++)
    begin
      u_host.set_order(o != 0);
      axi_wr(`REG_CFG_OFFSET, o == 2);
      u_host.cmd(3'b010, 1'b0, 1'b1, base);
      for (int k = 1; k <= 4; k++)
      begin
        u_host.cmd(3'b010, 1'b1, 1'b0, base);
        #1;
        lo = k[1:0];
        check(burst_addr, {base[19:2], (o == 1) ? (2'b01 ^ lo) : (2'b01 + lo)});
      end
    end
    axi_wr(`REG_CFG_OFFSET, 32'h0000_0000);
    u_host.cmd(3'b010, 1'b0, 1'b1, 20'h0_0333);
    u_host.set_sleep(1'b1);
    settle(2);
    check({snooze, inputs_ignored}, 2'b11);
    u_host.cmd(3'b010, 1'b0, 1'b1, 20'h0_0777);
    settle(1);
    check(burst_addr, 20'h0_0333);
    u_host.set_sleep(1'b0);
    #1;
    check(snooze, 1'b0);
    check(burst_addr, 20'h0_0333);
    u_host.cmd(3'b010, 1'b0, 1'b1, 20'h0_0444);
    #1;
    check(burst_addr, 20'h0_0444);
    axi_rd(`REG_BURST_ADDR_OFFSET);
    check(d, 32'h0000_0444);
    // Software sleep takes the same path as the pin
    axi_wr(`REG_CFG_OFFSET, 32'h0000_0002);
    settle(2);
    check(snooze, 1'b1);
    axi_rd(`REG_STATUS_OFFSET);
    check(d[1:0], 2'b11);
    axi_wr(`REG_CFG_OFFSET, 32'h0000_0000);
    settle(3);
    check(snooze, 1'b0);
    report_and_stop();
  end
endmodule
`default_nettype wire
